/* sucs_device.sv */
// module: system and usb clock source selector with its register file
// Operation
// - internal oscillator usable immediately once enabled
// - external clock drives system only at 001
// - external clock still feeds peripherals meanwhile
// - system source switchable live; pick stable sources
// - usb select: 00 mult, 01 int/2, 10 ext
// - usb select 11 stops usb clock
// - full speed needs 48 MHz usb clock
// - low speed needs 6 MHz usb clock
// - full speed setups: usb from multiplier on int, or ext direct with multiplier on ext
// - low speed setups: int/2 or ext direct
// - int oscillator undivided; recovery for multiplier
// - multiplier input: 0 internal, 1 external
module sucs_device
    import sucs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    sucs_if.dev bus,
    input wire logic int_osc_tick_i,
    input wire logic ext_clk_pin_i,
    input wire logic mult_tick_i,
    input wire logic lf_osc_tick_i,
    input wire logic ext_stable_i,
    input wire logic mult_ready_i,
    input wire logic lf_ready_i,
    output logic sys_clk_en_o,
    output logic usb_clk_en_o,
    output logic mult_ref_en_o,
    output logic ext_periph_en_o,
    output logic int_osc_en_o,
    output logic global_input_en_o
);
    // register file
    logic [7:0] srcsel_reg;
    logic [7:0] srcsel_next;
    logic [7:0] oscctl_reg;
    logic [7:0] oscctl_next;
    logic [7:0] mulctl_reg;
    logic [7:0] mulctl_next;
    logic [7:0] portctl_reg;
    logic [7:0] portctl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    // pin synchroniser and clock outputs
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic sys_reg;
    logic sys_next;
    logic usb_reg;
    logic usb_next;
    logic mref_reg;
    logic mref_next;
    logic eper_reg;
    logic eper_next;
    // derived ticks
    logic osc_en;
    logic input_en;
    logic int_raw;
    logic int_tick;
    logic int_half;
    logic mul_half;
    logic ext_tick;
    logic [3:0] stat;
    logic access;
    logic [2:0] sys_sel;
    logic [1:0] usb_sel;

    assign osc_en = oscctl_reg[SUCS_OSC_EN_BIT];
    assign input_en = portctl_reg[SUCS_INPUT_EN_BIT];
    assign sys_sel = srcsel_reg[SUCS_SYS_LSB +: 3];
    assign usb_sel = srcsel_reg[SUCS_USB_LSB +: 2];
    // no start-up wait: the enable bit alone gates the oscillator
    assign int_raw = int_osc_tick_i & osc_en;
    // external pin is only seen with global inputs on
    assign ext_tick = ext_s2_reg & ~ext_s3_reg & input_en;
    assign access = bus.req & ~ack_reg;

    always_comb begin
        stat = 4'h0;
        stat[SUCS_ST_INT] = osc_en;
        stat[SUCS_ST_EXT] = ext_stable_i & input_en;
        stat[SUCS_ST_MUL] = mult_ready_i;
        stat[SUCS_ST_LF] = lf_ready_i;
    end

    // divide field 11 is /1, 00 is /8
    sucs_tick_div #(
        .CW(3)
    ) u_osc_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(int_raw),
        .shift_i(~oscctl_reg[SUCS_OSC_DIV_LSB +: 2]),
        .tick_o(int_tick)
    );

    sucs_tick_div #(
        .CW(3)
    ) u_int_half (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(int_tick),
        .shift_i(2'h1),
        .tick_o(int_half)
    );

    sucs_tick_div #(
        .CW(3)
    ) u_mul_half (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(mult_tick_i),
        .shift_i(2'h1),
        .tick_o(mul_half)
    );

    // register access: one-cycle answer, reserved bits of multiplier and status read zero, of select only bits 7 and 3
    always_comb begin
        srcsel_next = srcsel_reg;
        oscctl_next = oscctl_reg;
        mulctl_next = mulctl_reg;
        portctl_next = portctl_reg;
        rdata_next = rdata_reg;
        ack_next = access;
        if (access && bus.we) begin
            case (bus.addr)
                SUCS_SRCSEL_ADDR: begin
                    // new source takes effect on the next tick, no handshake
                    srcsel_next = bus.wdata & SUCS_SRCSEL_MASK;
                end
                SUCS_OSCCTL_ADDR: begin
                    oscctl_next = bus.wdata;
                end
                SUCS_MULCTL_ADDR: begin
                    mulctl_next = bus.wdata & SUCS_MUL_FROM_EXT;
                end
                SUCS_PORTCTL_ADDR: begin
                    portctl_next = bus.wdata;
                end
                default: begin
                end
            endcase
        end
        if (access && !bus.we) begin
            case (bus.addr)
                SUCS_SRCSEL_ADDR: rdata_next = srcsel_reg;
                SUCS_OSCCTL_ADDR: rdata_next = oscctl_reg;
                SUCS_STAT_ADDR: rdata_next = {4'h0, stat};
                SUCS_MULCTL_ADDR: rdata_next = mulctl_reg;
                SUCS_PORTCTL_ADDR: rdata_next = portctl_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // clock source muxes
    always_comb begin
        // unlisted codes fall back to the internal oscillator, never stall the cpu
        case (sys_sel)
            SUCS_SYS_INT: sys_next = int_tick;
            SUCS_SYS_EXT: sys_next = ext_tick;
            SUCS_SYS_MUL: sys_next = mul_half;
            SUCS_SYS_LF: sys_next = lf_osc_tick_i;
            default: sys_next = int_tick;
        endcase
        case (usb_sel)
            SUCS_USB_MUL: usb_next = mult_tick_i;
            SUCS_USB_INT2: usb_next = int_half;
            SUCS_USB_EXT: usb_next = ext_tick;
            SUCS_USB_OFF: usb_next = 1'b0;
            default: usb_next = 1'b0;
        endcase
        mref_next = mulctl_reg[SUCS_MUL_SEL_BIT] ? ext_tick : int_tick;
        // peripherals keep the external clock whatever the system source
        eper_next = ext_tick;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srcsel_reg <= SUCS_SRCSEL_RST;
            oscctl_reg <= SUCS_OSCCTL_RST;
            mulctl_reg <= SUCS_MULCTL_RST;
            portctl_reg <= SUCS_PORTCTL_RST;
            rdata_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else begin
            srcsel_reg <= srcsel_next;
            oscctl_reg <= oscctl_next;
            mulctl_reg <= mulctl_next;
            portctl_reg <= portctl_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            sys_reg <= 1'b0;
            usb_reg <= 1'b0;
            mref_reg <= 1'b0;
            eper_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_clk_pin_i;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            sys_reg <= sys_next;
            usb_reg <= usb_next;
            mref_reg <= mref_next;
            eper_reg <= eper_next;
        end
    end

    assign bus.rdata = rdata_reg;
    assign bus.ack = ack_reg;
    assign sys_clk_en_o = sys_reg;
    assign usb_clk_en_o = usb_reg;
    assign mult_ref_en_o = mref_reg;
    assign ext_periph_en_o = eper_reg;
    assign int_osc_en_o = oscctl_reg[SUCS_OSC_EN_BIT];
    assign global_input_en_o = portctl_reg[SUCS_INPUT_EN_BIT];
endmodule // sucs_device

/* sucs_host.sv */
// module: wishbone-controlled host that programs the clock selector safely
module sucs_host
    import sucs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic clk_recovery_en_o,
    output logic usb_full_speed_o,
    sucs_if.host bus
);
    typedef enum logic [1:0] {
        SUCS_H_IDLE = 2'b00,
        SUCS_H_STAT = 2'b01,
        SUCS_H_WRITE = 2'b10
    } sucs_hstate_t;
    typedef enum logic [1:0] {
        SUCS_K_SYS = 2'b00,
        SUCS_K_USB = 2'b01,
        SUCS_K_PRE = 2'b10
    } sucs_kind_t;

    sucs_hstate_t st_reg, st_next;
    sucs_kind_t kind_reg, kind_next;
    logic [2:0] val_reg, val_next;
    logic [1:0] step_reg, step_next;
    logic [7:0] shadow_reg, shadow_next;
    logic [3:0] stat_reg, stat_next;
    logic refused_reg, refused_next;
    logic req_reg, req_next;
    logic we_reg, we_next;
    logic [7:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic crec_reg, crec_next;
    logic fs_reg, fs_next;
    logic wb_acc;
    logic wb_wr;
    logic [16:0] stp;

    // one write of a job: {last, addr, data}
    function automatic logic [16:0] sucs_step(sucs_kind_t k, logic [2:0] v, logic [1:0] s, logic [7:0] sh);
        logic [7:0] usbv;
        usbv = sh & ~SUCS_USB_MASK;
        sucs_step = {1'b1, SUCS_SRCSEL_ADDR, usbv};
        case (k)
            SUCS_K_SYS: sucs_step = {1'b1, SUCS_SRCSEL_ADDR, (sh & ~SUCS_SYS_MASK) | {5'h00, v}};
            SUCS_K_USB: sucs_step = {1'b1, SUCS_SRCSEL_ADDR, usbv | {2'h0, v[1:0], 4'h0}};
            default: begin
                case ({v, s})
                    {SUCS_PRE_FS_INT, 2'h0}: sucs_step = {1'b0, SUCS_OSCCTL_ADDR, SUCS_OSC_UNDIV};
                    {SUCS_PRE_FS_INT, 2'h1}: sucs_step = {1'b0, SUCS_MULCTL_ADDR, SUCS_MUL_FROM_INT};
                    {SUCS_PRE_FS_INT, 2'h2}: sucs_step = {1'b1, SUCS_SRCSEL_ADDR, usbv};
                    {SUCS_PRE_FS_EXT, 2'h0}: sucs_step = {1'b0, SUCS_PORTCTL_ADDR, SUCS_PORT_INEN};
                    {SUCS_PRE_FS_EXT, 2'h1}: sucs_step = {1'b0, SUCS_MULCTL_ADDR, SUCS_MUL_FROM_EXT};
                    {SUCS_PRE_FS_EXT, 2'h2}: sucs_step = {1'b1, SUCS_SRCSEL_ADDR, usbv | 8'h20};
                    {SUCS_PRE_LS_INT, 2'h0}: sucs_step = {1'b0, SUCS_OSCCTL_ADDR, SUCS_OSC_UNDIV};
                    {SUCS_PRE_LS_INT, 2'h1}: sucs_step = {1'b1, SUCS_SRCSEL_ADDR, usbv | 8'h10};
                    {SUCS_PRE_LS_EXT, 2'h0}: sucs_step = {1'b0, SUCS_PORTCTL_ADDR, SUCS_PORT_INEN};
                    {SUCS_PRE_LS_EXT, 2'h1}: sucs_step = {1'b1, SUCS_SRCSEL_ADDR, usbv | 8'h20};
                    default: sucs_step = {1'b1, SUCS_SRCSEL_ADDR, sh};
                endcase
            end
        endcase
    endfunction

    // is the job allowed given the device status just read
    function automatic logic sucs_ok(sucs_kind_t k, logic [2:0] v, logic [3:0] st);
        case (k)
            SUCS_K_SYS: sucs_ok = !v[2] && st[v[1:0]];
            SUCS_K_USB: begin
                case (v[1:0])
                    SUCS_USB_MUL: sucs_ok = st[SUCS_ST_MUL];
                    SUCS_USB_INT2: sucs_ok = st[SUCS_ST_INT];
                    SUCS_USB_EXT: sucs_ok = st[SUCS_ST_EXT];
                    default: sucs_ok = 1'b1;
                endcase
            end
            default: sucs_ok = (v != SUCS_PRE_NONE) && (v <= SUCS_PRE_LS_EXT);
        endcase
    endfunction

    assign wb_acc = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wb_wr = wb_acc & wb_we_i & wb_sel_i[0];
    assign stp = sucs_step(kind_reg, val_reg, step_reg, shadow_reg);

    always_comb begin
        st_next = st_reg;
        kind_next = kind_reg;
        val_next = val_reg;
        step_next = step_reg;
        shadow_next = shadow_reg;
        stat_next = stat_reg;
        refused_next = refused_reg;
        req_next = req_reg;
        we_next = we_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        crec_next = crec_reg;
        fs_next = fs_reg;
        ack_next = wb_acc;
        dat_next = 32'h0000_0000;
        if (wb_acc && !wb_we_i && wb_adr_i == SUCS_H_STAT_OFS) begin
            dat_next = {12'h000, stat_reg, shadow_reg, 6'h00, refused_reg, st_reg != SUCS_H_IDLE};
        end
        if (wb_wr && wb_adr_i == SUCS_H_STAT_OFS && wb_dat_i[1]) begin
            refused_next = 1'b0;
        end
        case (st_reg)
            SUCS_H_IDLE: begin
                if (wb_wr && wb_adr_i != SUCS_H_STAT_OFS) begin
                    kind_next = (wb_adr_i == SUCS_H_SYS_OFS) ? SUCS_K_SYS :
                                (wb_adr_i == SUCS_H_USB_OFS) ? SUCS_K_USB : SUCS_K_PRE;
                    val_next = wb_dat_i[2:0];
                    step_next = 2'h0;
                    req_next = 1'b1;
                    we_next = 1'b0;
                    addr_next = SUCS_STAT_ADDR;
                    st_next = SUCS_H_STAT;
                end
            end
            SUCS_H_STAT: begin
                if (bus.ack) begin
                    stat_next = bus.rdata[3:0];
                    if (sucs_ok(kind_reg, val_reg, bus.rdata[3:0])) begin
                        we_next = 1'b1;
                        addr_next = stp[15:8];
                        wdata_next = stp[7:0];
                        st_next = SUCS_H_WRITE;
                    end else begin
                        req_next = 1'b0;
                        refused_next = 1'b1;
                        st_next = SUCS_H_IDLE;
                    end
                end
            end
            SUCS_H_WRITE: begin
                if (bus.ack) begin
                    if (addr_reg == SUCS_SRCSEL_ADDR) begin
                        shadow_next = wdata_reg;
                    end
                    if (stp[16]) begin
                        req_next = 1'b0;
                        st_next = SUCS_H_IDLE;
                        if (kind_reg == SUCS_K_PRE) begin
                            fs_next = (val_reg == SUCS_PRE_FS_INT) || (val_reg == SUCS_PRE_FS_EXT);
                            crec_next = (val_reg == SUCS_PRE_FS_INT);
                        end
                    end else begin
                        step_next = step_reg + 2'h1;
                        st_next = SUCS_H_STAT;
                        we_next = 1'b0;
                        addr_next = SUCS_STAT_ADDR;
                    end
                end
            end
            default: st_next = SUCS_H_IDLE;
        endcase
        // job writes while busy are dropped; set wins over a clear
        if (wb_wr && wb_adr_i != SUCS_H_STAT_OFS && st_reg != SUCS_H_IDLE) begin
            refused_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= SUCS_H_IDLE;
            kind_reg <= SUCS_K_SYS;
            val_reg <= 3'h0;
            step_reg <= 2'h0;
            shadow_reg <= SUCS_SRCSEL_RST;
            stat_reg <= 4'h0;
            refused_reg <= 1'b0;
            req_reg <= 1'b0;
            we_reg <= 1'b0;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            crec_reg <= 1'b0;
            fs_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            kind_reg <= kind_next;
            val_reg <= val_next;
            step_reg <= step_next;
            shadow_reg <= shadow_next;
            stat_reg <= stat_next;
            refused_reg <= refused_next;
            req_reg <= req_next;
            we_reg <= we_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
            crec_reg <= crec_next;
            fs_reg <= fs_next;
        end
    end

    assign bus.req = req_reg;
    assign bus.we = we_reg;
    assign bus.addr = addr_reg;
    assign bus.wdata = wdata_reg;
    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign clk_recovery_en_o = crec_reg;
    assign usb_full_speed_o = fs_reg;
endmodule // sucs_host

/* sucs_if.sv */
// interface: register access channel between host controller and selector
interface sucs_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
    modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

/* sucs_pkg.sv */
// package: register map, field layout, encodings for the clock selector pair
package sucs_pkg;
    // device register addresses
    localparam logic [7:0] SUCS_SRCSEL_ADDR = 8'ha9;
    localparam logic [7:0] SUCS_OSCCTL_ADDR = 8'hb2;
    localparam logic [7:0] SUCS_STAT_ADDR = 8'hb3;
    localparam logic [7:0] SUCS_MULCTL_ADDR = 8'hb9;
    localparam logic [7:0] SUCS_PORTCTL_ADDR = 8'he2;
    // reset values
    localparam logic [7:0] SUCS_SRCSEL_RST = 8'h00;
    localparam logic [7:0] SUCS_OSCCTL_RST = 8'h80;
    localparam logic [7:0] SUCS_MULCTL_RST = 8'h00;
    localparam logic [7:0] SUCS_PORTCTL_RST = 8'h40;
    // field positions and masks
    localparam logic [7:0] SUCS_SRCSEL_MASK = 8'h77;
    localparam logic [7:0] SUCS_SYS_MASK = 8'h07;
    localparam logic [7:0] SUCS_USB_MASK = 8'h30;
    localparam int SUCS_SYS_LSB = 0;
    localparam int SUCS_USB_LSB = 4;
    localparam int SUCS_OSC_EN_BIT = 7;
    localparam int SUCS_OSC_DIV_LSB = 0;
    localparam int SUCS_MUL_SEL_BIT = 0;
    localparam int SUCS_INPUT_EN_BIT = 6;
    // status bits, indexed by system source code
    localparam int SUCS_ST_INT = 0;
    localparam int SUCS_ST_EXT = 1;
    localparam int SUCS_ST_MUL = 2;
    localparam int SUCS_ST_LF = 3;
    // preset register values
    localparam logic [7:0] SUCS_OSC_UNDIV = 8'h83;
    localparam logic [7:0] SUCS_PORT_INEN = 8'h40;
    localparam logic [7:0] SUCS_MUL_FROM_EXT = 8'h01;
    localparam logic [7:0] SUCS_MUL_FROM_INT = 8'h00;
    // host wishbone offsets
    localparam logic [3:0] SUCS_H_SYS_OFS = 4'h0;
    localparam logic [3:0] SUCS_H_USB_OFS = 4'h4;
    localparam logic [3:0] SUCS_H_PRE_OFS = 4'h8;
    localparam logic [3:0] SUCS_H_STAT_OFS = 4'hc;

    typedef enum logic [2:0] {
        SUCS_SYS_INT = 3'b000,
        SUCS_SYS_EXT = 3'b001,
        SUCS_SYS_MUL = 3'b010,
        SUCS_SYS_LF = 3'b011
    } sucs_sys_src_t;

    typedef enum logic [1:0] {
        SUCS_USB_MUL = 2'b00,
        SUCS_USB_INT2 = 2'b01,
        SUCS_USB_EXT = 2'b10,
        SUCS_USB_OFF = 2'b11
    } sucs_usb_src_t;

    typedef enum logic [2:0] {
        SUCS_PRE_NONE = 3'b000,
        SUCS_PRE_FS_INT = 3'b001,
        SUCS_PRE_FS_EXT = 3'b010,
        SUCS_PRE_LS_INT = 3'b011,
        SUCS_PRE_LS_EXT = 3'b100
    } sucs_preset_t;
endpackage

/* sucs_properties.sv */
// checker: timing and content of the register channel between host and selector
module sucs_properties
    import sucs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic osc_reg, osc_next;
    logic [3:0] st_reg, st_next;
    logic [2:0] sys_reg, sys_next;
    logic [1:0] usb_reg, usb_next;
    // shadows follow acked transfers only, as the device does
    always_comb begin
        osc_next = osc_reg;
        st_next = st_reg;
        sys_next = sys_reg;
        usb_next = usb_reg;
        if (ack && we && addr == SUCS_OSCCTL_ADDR) osc_next = wdata[7];
        if (ack && we && addr == SUCS_SRCSEL_ADDR) begin
            sys_next = wdata[2:0];
            usb_next = wdata[5:4];
        end
        if (ack && !we && addr == SUCS_STAT_ADDR) st_next = rdata[3:0];
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_reg <= 1'b1;
            st_reg <= 4'h0;
            sys_reg <= 3'h0;
            usb_reg <= 2'h0;
        end else begin
            osc_reg <= osc_next;
            st_reg <= st_next;
            sys_reg <= sys_next;
            usb_reg <= usb_next;
        end
    end
    sequence s_take; req && !ack; endsequence
    sequence s_stat_rd; s_take ##0 (!we && addr == SUCS_STAT_ADDR); endsequence
    sequence s_sel_wr; s_take ##0 (we && addr == SUCS_SRCSEL_ADDR); endsequence
    chk_ack_timing: assert property (s_take |=> ack) else $error("no ack after request");
    chk_ack_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    chk_ack_cause: assert property (ack |-> $past(req)) else $error("ack without request");
    chk_rdata_hold: assert property (!(ack && !we) |-> $stable(rdata)) else $error("read data moved");
    chk_osc_status: assert property (s_stat_rd |=> rdata[0] == osc_reg) else $error("osc status wrong");
    chk_stat_spare: assert property (s_stat_rd |=> rdata[7:4] == 4'h0) else $error("status spare bits set");
    chk_sel_layout: assert property (s_sel_wr |-> (wdata & ~SUCS_SRCSEL_MASK) == 8'h00)
        else $error("select write touches unused bits");
    chk_sys_ready: assert property (s_sel_wr ##0 (wdata[2:0] != sys_reg) |-> !wdata[2] && st_reg[wdata[1:0]])
        else $error("system source not ready");
    // only a change of the usb field to the multiplier needs its lock
    chk_usb_mult: assert property (s_sel_wr ##0 (wdata[5:4] == 2'b00 && usb_reg != 2'b00) |-> st_reg[2])
        else $error("multiplier not ready");
endmodule // sucs_properties

/* sucs_tick_div.sv */
// module: divides an enable-pulse stream by 1, 2, 4 or 8
module sucs_tick_div #(
    parameter int CW = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [1:0] shift_i,
    output logic tick_o
);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    logic [CW-1:0] mask;

    generate
        if (CW < 3) begin : g_chk
            $error("sucs_tick_div: CW must be at least 3");
        end
    endgenerate

    always_comb begin
        mask = CW'((8'h01 << shift_i) - 8'h01);
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (tick_i) begin
            if ((cnt_reg & mask) == mask) begin
                cnt_next = '0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;
endmodule // sucs_tick_div

/* system_usb_clock_select_test.sv */
// testbench: host and selector joined over the register channel
module system_usb_clock_select_test import sucs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, lf_rdy = 1, mul_rdy = 1;
    logic int_t = 0, mul_t = 0, lf_t = 0, pin = 0;
    logic ack, recov, fs, sys_en, usb_en, ext_en, osc_en, gin_en, mref;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0000_0000, q, dat_o;
    int cnt = 0, fail_count = 0, n_checks = 0, s, u, e, m;
    // adr, data, watch 0 sys 1 usb 2 mult ref, pulses per 420 cycles
    int rows[13][4] = '{'{0, 1, 0, 42}, '{0, 0, 0, 26}, '{0, 2, 0, 70}, '{0, 3, 0, 60}, '{4, 0, 1, 140},
        '{4, 2, 1, 42}, '{4, 3, 1, 0}, '{8, 3, 1, 105}, '{8, 2, 2, 42}, '{8, 4, 1, 42}, '{8, 1, 1, 140},
        '{0, 0, 0, 210}, '{0, 0, 2, 210}};
    sucs_if bus();
    sucs_device u_sucs_device (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .int_osc_tick_i(int_t),
        .ext_clk_pin_i(pin), .mult_tick_i(mul_t), .lf_osc_tick_i(lf_t), .ext_stable_i(1'b1),
        .mult_ready_i(mul_rdy), .lf_ready_i(lf_rdy), .sys_clk_en_o(sys_en), .usb_clk_en_o(usb_en),
        .mult_ref_en_o(mref), .ext_periph_en_o(ext_en), .int_osc_en_o(osc_en), .global_input_en_o(gin_en));
    sucs_host u_sucs_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .clk_recovery_en_o(recov), .usb_full_speed_o(fs), .bus(bus));
    sucs_properties u_sucs_properties (.clk_i(clk_i), .rst_i(rst_i), .req(bus.req), .we(bus.we),
        .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack));
    initial forever #50 clk_i = ~clk_i;
    // distinct source rates so a wrong route shows as a wrong count
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
        int_t <= (cnt % 2 == 0);
        mul_t <= (cnt % 3 == 0);
        lf_t <= (cnt % 7 == 0);
        pin <= (cnt % 10 < 5);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // called just after a rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 60);
        q = dat_o;
        if (n >= 60) fail_count++;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask
    task automatic job(input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb(1, a, d);
        do begin
            wb(0, SUCS_H_STAT_OFS, 0);
            k++;
        end while (q[0] !== 1'b0 && k < 40);
        if (q[0] !== 1'b0) fail_count++;
    endtask
    // first 40 cycles let the new route settle
    task automatic meas;
        s = 0;
        u = 0;
        e = 0;
        m = 0;
        repeat (40) @(posedge clk_i);
        repeat (420) begin
            @(posedge clk_i);
            s += sys_en;
            u += usb_en;
            e += ext_en;
            m += mref;
        end
    endtask
    function automatic logic [31:0] near(int v, int x);
        return {31'b0, v >= x - 2 && v <= x + 2};
    endfunction
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk_i);
        fail_count++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk(osc_en, 1);
        chk(gin_en, 1);
        for (int i = 0; i < 13; i++) begin
            job(4'(rows[i][0]), 32'(rows[i][1]));
            meas;
            chk(near(rows[i][2] == 2 ? m : rows[i][2] ? u : s, rows[i][3]), 1);
            chk(near(e, 42), 1);
        end
        chk(fs, 1);
        chk(recov, 1);
        wb(0, 4'h2, 0);
        chk(q, 0);
        rst_i <= 1;
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk(fs, 0);
        chk(recov, 0);
        wb(0, SUCS_H_STAT_OFS, 0);
        chk(q[15:0], 0);
        lf_rdy <= 0;
        job(SUCS_H_SYS_OFS, 3);
        chk(q[1], 1);
        chk(q[15:8], 0);
        meas;
        chk(near(s, 26), 1);
        // clear refused, then a usb job without multiplier lock
        wb(1, SUCS_H_STAT_OFS, 2);
        wb(0, SUCS_H_STAT_OFS, 0);
        chk(q[1], 0);
        mul_rdy <= 0;
        job(SUCS_H_USB_OFS, 0);
        chk(q[1], 1);
        // a second job while the first still runs is dropped
        wb(1, SUCS_H_STAT_OFS, 2);
        wb(1, SUCS_H_SYS_OFS, 1);
        job(SUCS_H_SYS_OFS, 0);
        chk(q[1], 1);
        chk(q[15:8], 1);
        test_done;
    end
endmodule // system_usb_clock_select_test
